// ==== core/osg_status_top.sv ====
// Operation status group: condition, transition filters, event, enable and summary
`timescale 1ns/10ps
`include "osg_defines.svh"
module osg_status_top
    import osg_pkg::*;
#(
    parameter int LEVEL_W = 16,
    parameter int AVG_W   = 16
) (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire logic                   range_search_active,
    input  wire logic                   current_leads_voltage,
    input  wire logic                   integ_time_up,
    input  wire logic                   integ_running,
    input  wire logic                   integ_paused,
    input  wire logic                   acquisition_active,
    input  wire logic                   trigger_wait,
    input  wire logic [AVG_W-1:0]       avg_count,
    input  wire logic [AVG_W-1:0]       avg_target,
    input  wire logic [LEVEL_W-1:0]     current_level,
    input  wire logic [LEVEL_W-1:0]     current_mute_level,
    input  wire logic [LEVEL_W-1:0]     voltage_level,
    input  wire logic [LEVEL_W-1:0]     voltage_mute_level,
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire osg_cmd_t               cmd_code,
    input  wire logic [`OSG_REG_W-1:0]  cmd_value,
    output logic                        cmd_error,
    output logic                        resp_valid,
    output logic [`OSG_REG_W-1:0]       resp_value,
    output logic [`OSG_TEXT_W-1:0]      resp_text,
    output logic [2:0]                  resp_len,
    output logic                        normal_activity_summary
);

    // Refused at elaboration: a zero-width compare means nothing
    if (LEVEL_W < 1 || AVG_W < 1) begin : g_width_check
        $error("osg_status_top: level and average widths must be at least one");
    end

    osg_state_t s;
    osg_state_t next_s;
    osg_fmt_if  fmt_bus ();

    osg_nr1_fmt u_fmt (
        .clk  (clk),
        .srst (srst),
        .fi   (fmt_bus.fmt)
    );

    function automatic logic is_query(input osg_cmd_t c);
        return (c == OSG_CMD_EVENT_Q) || (c == OSG_CMD_COND_Q) ||
               (c == OSG_CMD_ENAB_Q)  || (c == OSG_CMD_NTR_Q)  ||
               (c == OSG_CMD_PTR_Q);
    endfunction

    function automatic logic is_set(input osg_cmd_t c);
        return (c == OSG_CMD_ENAB_SET) || (c == OSG_CMD_NTR_SET) ||
               (c == OSG_CMD_PTR_SET);
    endfunction

    logic                   accept;
    logic                   write_ok;
    logic [`OSG_REG_W-1:0]  live_cond;
    logic [`OSG_REG_W-1:0]  edges;
    logic [`OSG_REG_W-1:0]  write_val;

    // Only one query may be in formatting at a time
    assign cmd_ready = (s.state == OSG_IDLE);
    assign accept    = cmd_valid && cmd_ready;
    assign write_ok  = (cmd_value <= `OSG_WRITE_MAX);
    assign write_val = cmd_value & `OSG_USED_MASK;

    always_comb begin
        live_cond = `OSG_ZERO16;
        live_cond[`OSG_BIT_RANGE] = range_search_active;
        live_cond[`OSG_BIT_LEAD] = current_leads_voltage;
        live_cond[`OSG_BIT_TIME_UP] = integ_time_up;
        live_cond[`OSG_BIT_TRIG_WAIT] = trigger_wait;
        live_cond[`OSG_BIT_INTEG] = integ_running || integ_paused;
        live_cond[`OSG_BIT_ACQ] = acquisition_active;
        live_cond[`OSG_BIT_AVG] = (avg_count < avg_target);
        live_cond[`OSG_BIT_I_MUTE] = (current_level <= current_mute_level);
        live_cond[`OSG_BIT_V_MUTE] = (voltage_level <= voltage_mute_level);
    end

    // filtered transitions of the registered condition
    assign edges = ((s.cond & ~s.cond_prev & s.ptr) |
                    (~s.cond & s.cond_prev & s.ntr)) & `OSG_USED_MASK;

    always_comb begin
        next_s = s;
        next_s.cmd_error = 1'b0;
        next_s.fmt_start = 1'b0;
        next_s.resp_valid = 1'b0;
        next_s.cond = live_cond & `OSG_USED_MASK;
        next_s.cond_prev = s.cond;
        // events stick; a new edge beats a clearing read
        next_s.event_bits = s.event_bits | edges;
        case (s.state)
            OSG_IDLE: begin
                if (accept) begin
                    if (is_query(cmd_code)) begin
                        next_s.fmt_start = 1'b1;
                        next_s.state = OSG_FORMAT;
                    end
                    case (cmd_code)
                        OSG_CMD_EVENT_Q: begin
                            // read returns events then clears them
                            next_s.resp_value = s.event_bits;
                            next_s.event_bits = edges;
                        end
                        OSG_CMD_COND_Q: begin
                            next_s.resp_value = s.cond;
                        end
                        OSG_CMD_ENAB_Q: begin
                            next_s.resp_value = s.enable;
                        end
                        OSG_CMD_NTR_Q: begin
                            next_s.resp_value = s.ntr;
                        end
                        OSG_CMD_PTR_Q: begin
                            next_s.resp_value = s.ptr;
                        end
                        OSG_CMD_ENAB_SET: begin
                            // enable store, out of range refused
                            if (write_ok) begin
                                next_s.enable = write_val;
                            end
                        end
                        OSG_CMD_NTR_SET: begin
                            if (write_ok) begin
                                next_s.ntr = write_val;
                            end
                        end
                        OSG_CMD_PTR_SET: begin
                            if (write_ok) begin
                                next_s.ptr = write_val;
                            end
                        end
                        default: begin
                            next_s.cmd_error = 1'b1;
                        end
                    endcase
                    if (is_set(cmd_code) && !write_ok) begin
                        next_s.cmd_error = 1'b1;
                    end
                end
            end
            OSG_FORMAT: begin
                if (fmt_bus.done) begin
                    next_s.resp_valid = 1'b1;
                    next_s.resp_text = fmt_bus.text;
                    next_s.resp_len = fmt_bus.len;
                    next_s.state = OSG_IDLE;
                end
            end
            default: begin
                next_s.state = OSG_IDLE;
            end
        endcase
        next_s.summary = |(next_s.event_bits & next_s.enable);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.enable <= `OSG_ENABLE_RESET;
            s.ntr <= `OSG_NTR_RESET;
            s.ptr <= `OSG_PTR_RESET & `OSG_USED_MASK;
        end else begin
            s <= next_s;
        end
    end

    assign fmt_bus.start           = s.fmt_start;
    assign fmt_bus.value           = s.resp_value;
    assign cmd_error               = s.cmd_error;
    assign resp_valid              = s.resp_valid;
    assign resp_value              = s.resp_value;
    assign resp_text               = s.resp_text;
    assign resp_len                = s.resp_len;
    assign normal_activity_summary = s.summary;

    // Guards on the behaviour above

    a_integ_cond_bit: assert property (@(posedge clk) disable iff (srst)
        (integ_running || integ_paused) |=> s.cond[`OSG_BIT_INTEG])
        else $error("integration bit low while integrating or paused");

    a_mute_cond_bit: assert property (@(posedge clk) disable iff (srst)
        (current_level <= current_mute_level) |=> s.cond[`OSG_BIT_I_MUTE])
        else $error("current mute bit low at or below threshold");

    a_avg_cond_bit: assert property (@(posedge clk) disable iff (srst)
        !(avg_count < avg_target) |=> !s.cond[`OSG_BIT_AVG])
        else $error("average bit high after count reached");

    a_unused_bits_zero: assert property (@(posedge clk) disable iff (srst)
        ((s.cond | s.event_bits | s.enable | s.ntr | s.ptr) & ~`OSG_USED_MASK) == 16'h0000)
        else $error("unused status bit reads nonzero");

    a_edge_latch_event: assert property (@(posedge clk) disable iff (srst)
        (edges != 16'h0000) |=> ((s.event_bits & $past(edges)) == $past(edges)))
        else $error("filtered transition did not latch an event");

    a_event_read_clear: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_EVENT_Q && edges == 16'h0000)
        |=> (s.event_bits == 16'h0000) && (s.resp_value == $past(s.event_bits)))
        else $error("event read did not return and clear");

    a_cond_read_keeps: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_COND_Q)
        |=> (s.event_bits == ($past(s.event_bits) | $past(edges))))
        else $error("condition read disturbed events");

    a_query_answer_time: assert property (@(posedge clk) disable iff (srst)
        (accept && is_query(cmd_code)) |=> !resp_valid [*8] ##1 !resp_valid [*8]
        ##1 !resp_valid [*3] ##1 resp_valid)
        else $error("query answer not on the expected cycle");

    a_enable_range: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_ENAB_SET && !write_ok)
        |=> $stable(s.enable) && cmd_error)
        else $error("out of range enable write not refused");

    a_ptr_write_store: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_PTR_SET && write_ok)
        |=> s.ptr == ($past(cmd_value) & `OSG_USED_MASK))
        else $error("rising filter write not stored");

    a_summary_match: assert property (@(posedge clk) disable iff (srst)
        normal_activity_summary == |(s.event_bits & s.enable))
        else $error("summary disagrees with enabled events");

    a_range_cond_bit: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> s.cond[`OSG_BIT_RANGE] == $past(range_search_active))
        else $error("range search bit does not follow its source");

    a_lead_cond_bit: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> s.cond[`OSG_BIT_LEAD] == $past(current_leads_voltage))
        else $error("phase lead bit does not follow its source");

    a_acq_cond_bit: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> s.cond[`OSG_BIT_ACQ] == $past(acquisition_active))
        else $error("acquisition bit does not follow its source");

    a_vmute_cond_bit: assert property (@(posedge clk) disable iff (srst)
        (voltage_level <= voltage_mute_level) |=> s.cond[`OSG_BIT_V_MUTE])
        else $error("voltage mute bit low at or below threshold");

    a_wait_cond_bits: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> s.cond[`OSG_BIT_TIME_UP] == $past(integ_time_up)
            && s.cond[`OSG_BIT_TRIG_WAIT] == $past(trigger_wait))
        else $error("time-up or trigger wait bit does not follow its source");

    a_ntr_write_store: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_NTR_SET && write_ok)
        |=> s.ntr == ($past(cmd_value) & `OSG_USED_MASK))
        else $error("falling filter write not stored");

    a_enable_write_store: assert property (@(posedge clk) disable iff (srst)
        (accept && cmd_code == OSG_CMD_ENAB_SET && write_ok)
        |=> s.enable == ($past(cmd_value) & `OSG_USED_MASK))
        else $error("enable write not stored");

    a_fmt_busy_format: assert property (@(posedge clk) disable iff (srst)
        fmt_bus.busy |-> (s.state == OSG_FORMAT) && !cmd_ready)
        else $error("formatter busy while group idle");

    a_set_no_answer: assert property (@(posedge clk) disable iff (srst)
        (accept && is_set(cmd_code)) |=> cmd_ready && !resp_valid)
        else $error("setting blocked the port or raised an answer");

endmodule

// ==== include/osg_defines.svh ====
// Constants of the operation status group: bit positions, masks, limits, reset values
`ifndef OSG_DEFINES_SVH
`define OSG_DEFINES_SVH

`define OSG_REG_W          16
`define OSG_BIT_RANGE      0
`define OSG_BIT_LEAD       1
`define OSG_BIT_TIME_UP    2
`define OSG_BIT_INTEG      3
`define OSG_BIT_ACQ        4
`define OSG_BIT_TRIG_WAIT  5
`define OSG_BIT_AVG        6
`define OSG_BIT_I_MUTE     8
`define OSG_BIT_V_MUTE     9
`define OSG_USED_MASK      16'h037f
`define OSG_WRITE_MAX      16'h7fff
`define OSG_ZERO16         16'h0000
`define OSG_ENABLE_RESET   16'h0000
`define OSG_NTR_RESET      16'h0000
`define OSG_PTR_RESET      16'h7fff

`define OSG_NR1_DIGITS     5
`define OSG_BCD_W          20
`define OSG_TEXT_W         40
`define OSG_SHIFT_LAST     5'h0f
`define OSG_BCD_LIMIT      4'h5
`define OSG_BCD_ADJUST     4'h3
`define OSG_ASCII_ZERO     8'h30
`define OSG_LEN_MIN        3'h1
`define OSG_LEN_FULL       3'h5

`endif

// ==== include/osg_pkg.sv ====
// Types shared by the operation status group and its decimal formatter
package osg_pkg;
`include "osg_defines.svh"

    typedef enum logic [2:0] {
        OSG_CMD_EVENT_Q,
        OSG_CMD_COND_Q,
        OSG_CMD_ENAB_SET,
        OSG_CMD_ENAB_Q,
        OSG_CMD_NTR_SET,
        OSG_CMD_NTR_Q,
        OSG_CMD_PTR_SET,
        OSG_CMD_PTR_Q
    } osg_cmd_t;

    typedef enum logic {
        OSG_IDLE,
        OSG_FORMAT
    } osg_seq_t;

    typedef enum logic [1:0] {
        OSG_FMT_IDLE,
        OSG_FMT_SHIFT,
        OSG_FMT_DONE
    } osg_fmt_seq_t;

    typedef struct packed {
        osg_seq_t                 state;
        logic [`OSG_REG_W-1:0]    cond;
        logic [`OSG_REG_W-1:0]    cond_prev;
        logic [`OSG_REG_W-1:0]    event_bits;
        logic [`OSG_REG_W-1:0]    enable;
        logic [`OSG_REG_W-1:0]    ntr;
        logic [`OSG_REG_W-1:0]    ptr;
        logic                     summary;
        logic                     cmd_error;
        logic                     fmt_start;
        logic                     resp_valid;
        logic [`OSG_REG_W-1:0]    resp_value;
        logic [`OSG_TEXT_W-1:0]   resp_text;
        logic [2:0]               resp_len;
    } osg_state_t;

    typedef struct packed {
        osg_fmt_seq_t             state;
        logic [`OSG_REG_W-1:0]    bin;
        logic [`OSG_BCD_W-1:0]    bcd;
        logic [4:0]               count;
        logic                     done;
        logic [`OSG_TEXT_W-1:0]   text;
        logic [2:0]               len;
    } osg_fmt_state_t;

endpackage

// ==== include/osg_fmt_if.sv ====
// Carrier between the status group and its binary-to-decimal formatter
`timescale 1ns/10ps
interface osg_fmt_if;
    logic                    start;
    logic [15:0]             value;
    logic                    busy;
    logic                    done;
    logic [39:0]             text;
    logic [2:0]              len;

    modport fmt (
        input  start,
        input  value,
        output busy,
        output done,
        output text,
        output len
    );

    modport user (
        output start,
        output value,
        input  busy,
        input  done,
        input  text,
        input  len
    );
endinterface

// ==== core/osg_nr1_fmt.sv ====
// Sequential binary to decimal text formatter, one shift per cycle
`timescale 1ns/10ps
`include "osg_defines.svh"
module osg_nr1_fmt
    import osg_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      srst,
    osg_fmt_if.fmt         fi
);

    osg_fmt_state_t s;
    osg_fmt_state_t next_s;

    // Add three to every digit of five or more before the shift
    function automatic logic [`OSG_BCD_W-1:0] bcd_adjust(input logic [`OSG_BCD_W-1:0] v);
        logic [`OSG_BCD_W-1:0] r;
        r = v;
        for (int i = 0; i < `OSG_NR1_DIGITS; i++) begin
            if (r[4*i +: 4] >= `OSG_BCD_LIMIT) begin
                r[4*i +: 4] = r[4*i +: 4] + `OSG_BCD_ADJUST;
            end
        end
        return r;
    endfunction

    // Significant digits, never fewer than one so zero prints as "0"
    function automatic logic [2:0] digit_count(input logic [`OSG_BCD_W-1:0] v);
        logic [2:0] n;
        n = `OSG_LEN_MIN;
        for (int i = 1; i < `OSG_NR1_DIGITS; i++) begin
            if (v[4*i +: 4] != 4'h0) begin
                n = 3'(i + 1);
            end
        end
        return n;
    endfunction

    function automatic logic [`OSG_TEXT_W-1:0] to_ascii(input logic [`OSG_BCD_W-1:0] v);
        logic [`OSG_TEXT_W-1:0] t;
        t = '0;
        for (int i = 0; i < `OSG_NR1_DIGITS; i++) begin
            t[8*i +: 8] = `OSG_ASCII_ZERO + {4'h0, v[4*i +: 4]};
        end
        return t;
    endfunction

    always_comb begin
        logic [`OSG_BCD_W-1:0] adj;
        adj = bcd_adjust(s.bcd);
        next_s = s;
        next_s.done = 1'b0;
        case (s.state)
            OSG_FMT_IDLE: begin
                if (fi.start) begin
                    next_s.bin = fi.value;
                    next_s.bcd = '0;
                    next_s.count = '0;
                    next_s.state = OSG_FMT_SHIFT;
                end
            end
            OSG_FMT_SHIFT: begin
                {next_s.bcd, next_s.bin} = {adj[`OSG_BCD_W-2:0], s.bin, 1'b0};
                next_s.count = s.count + 5'h01;
                if (s.count == `OSG_SHIFT_LAST) begin
                    next_s.state = OSG_FMT_DONE;
                end
            end
            OSG_FMT_DONE: begin
                next_s.done = 1'b1;
                next_s.text = to_ascii(s.bcd);
                next_s.len = digit_count(s.bcd);
                next_s.state = OSG_FMT_IDLE;
            end
            default: begin
                next_s.state = OSG_FMT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fi.busy = (s.state != OSG_FMT_IDLE);
    assign fi.done = s.done;
    assign fi.text = s.text;
    assign fi.len  = s.len;

endmodule

// ==== test/osg_host_model.sv ====
// Remote controller model issuing status commands and awaiting answers
`timescale 1ns/10ps
module osg_host_model
    import osg_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   cmd_ready,
    input  wire logic   resp_valid,
    output logic        cmd_valid,
    output osg_cmd_t    cmd_code,
    output logic [15:0] cmd_value
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = OSG_CMD_COND_Q;
        cmd_value = 16'h5a5a;
    end

    // Request held until taken, then released; answer awaited under a bound
    task automatic issue(input osg_cmd_t code, input logic [15:0] val, output bit ok);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code  <= code;
        cmd_value <= val;
        do begin
            @(posedge clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 40);
        ok = (cmd_ready === 1'b1);
        cmd_valid <= 1'b0;
        // Released bus never shows the last value
        cmd_value <= ~val;
        if (ok && !(code inside {OSG_CMD_ENAB_SET, OSG_CMD_NTR_SET, OSG_CMD_PTR_SET})) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (resp_valid !== 1'b1 && n < 40);
            ok = (resp_valid === 1'b1);
        end
    endtask
endmodule

// ==== test/osg_status_top_tb.sv ====
// Self-checking bench of the operation status group against a reference model
`timescale 1ns/10ps
module osg_status_top_tb
    import osg_pkg::*;
;
    logic        clk, srst, cmd_valid, cmd_ready, cmd_error, resp_valid;
    logic        range_search_active, current_leads_voltage, integ_time_up, integ_running;
    logic        integ_paused, acquisition_active, trigger_wait, normal_activity_summary;
    logic [15:0] avg_count, avg_target, current_level, current_mute_level;
    logic [15:0] voltage_level, voltage_mute_level, cmd_value, resp_value;
    osg_cmd_t    cmd_code;
    logic [39:0] resp_text;
    logic [2:0]  resp_len;
    logic [15:0] m_cond, m_prev, m_ev, m_en, m_ntr, m_ptr, m_resp, nev, wr;
    logic        m_rv, m_err, m_sum, acc;
    int          m_cnt, miscompares = 0, total_checks = 0, cycles = 0;
    logic [15:0] wt [10] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0008,
                             16'h0010, 16'h0020, 16'h0040, 16'h0100, 16'h0200};
    wire logic [15:0] live = {6'h00, voltage_level <= voltage_mute_level,
        current_level <= current_mute_level, 1'b0, avg_count < avg_target, trigger_wait,
        acquisition_active, integ_running | integ_paused, integ_time_up,
        current_leads_voltage, range_search_active};

    initial clk = 1'b0;
    always #5 clk = ~clk;

    osg_status_top i_dut (
        .clk(clk), .srst(srst), .range_search_active(range_search_active),
        .current_leads_voltage(current_leads_voltage), .integ_time_up(integ_time_up),
        .integ_running(integ_running), .integ_paused(integ_paused),
        .acquisition_active(acquisition_active), .trigger_wait(trigger_wait),
        .avg_count(avg_count), .avg_target(avg_target), .current_level(current_level),
        .current_mute_level(current_mute_level), .voltage_level(voltage_level),
        .voltage_mute_level(voltage_mute_level), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_value(cmd_value),
        .cmd_error(cmd_error), .resp_valid(resp_valid), .resp_value(resp_value),
        .resp_text(resp_text), .resp_len(resp_len),
        .normal_activity_summary(normal_activity_summary)
    );

    osg_host_model i_host (
        .clk(clk), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_value(cmd_value)
    );

    function automatic logic [42:0] dec_of(input logic [15:0] v);
        int x, n;
        logic [39:0] t;
        x = v;
        n = 1;
        for (int i = 0; i < 5; i++) begin
            t[8*i +: 8] = 8'h30 + 8'(x % 10);
            x = x / 10;
        end
        for (x = v; x >= 10; x = x / 10) n++;
        return {3'(n), t};
    endfunction

    // Reference model, updated on the same edge as the group
    always @(posedge clk) begin
        if (srst) begin
            {m_cond, m_prev, m_ev, m_en, m_ntr, m_resp} = '0;
            m_ptr = 16'h037f;
            {m_cnt, m_rv, m_err, m_sum} = '0;
        end else begin
            acc = (cmd_valid === 1'b1) && (m_cnt == 0);
            m_rv = (m_cnt == 1);
            if (m_cnt > 0) m_cnt--;
            nev = (m_cond & ~m_prev & m_ptr) | (~m_cond & m_prev & m_ntr);
            wr = cmd_value & 16'h037f;
            m_err = acc && cmd_value > 16'h7fff
                    && cmd_code inside {OSG_CMD_ENAB_SET, OSG_CMD_NTR_SET, OSG_CMD_PTR_SET};
            if (acc) begin
                case (cmd_code)
                    OSG_CMD_EVENT_Q: m_resp = m_ev;
                    OSG_CMD_COND_Q:  m_resp = m_cond;
                    OSG_CMD_ENAB_Q:  m_resp = m_en;
                    OSG_CMD_NTR_Q:   m_resp = m_ntr;
                    OSG_CMD_PTR_Q:   m_resp = m_ptr;
                    OSG_CMD_ENAB_SET: if (!m_err) m_en = wr;
                    OSG_CMD_NTR_SET:  if (!m_err) m_ntr = wr;
                    default:          if (!m_err) m_ptr = wr;
                endcase
                if (!(cmd_code inside {OSG_CMD_ENAB_SET, OSG_CMD_NTR_SET, OSG_CMD_PTR_SET}))
                    m_cnt = 19;
            end
            m_ev = ((acc && cmd_code == OSG_CMD_EVENT_Q) ? 16'h0000 : m_ev) | nev;
            m_prev = m_cond;
            m_cond = live;
            m_sum = |(m_ev & m_en);
        end
    end

    always @(negedge clk) begin
        if (srst === 1'b0) begin
            chk(normal_activity_summary, m_sum);
            chk(cmd_error, m_err);
            chk(resp_valid, m_rv);
            chk(cmd_ready, m_cnt == 0);
            chk(resp_value, m_resp);
            if (m_rv) chk({resp_len, resp_text}, dec_of(m_resp));
        end
    end

    // Hang guard: whole run needs under two thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic send(input osg_cmd_t c, input logic [15:0] v);
        bit done_ok;
        i_host.issue(c, v, done_ok);
        if (!done_ok) begin
            miscompares++;
            $display("mismatch at %0t: command not answered", $time);
        end
    endtask

    task automatic q(input osg_cmd_t c, input logic [15:0] exp);
        send(c, 16'h0000);
        chk(resp_value, exp);
    endtask

    task automatic idle();
        {range_search_active, current_leads_voltage, integ_time_up, integ_running} <= '0;
        {integ_paused, acquisition_active, trigger_wait} <= '0;
        {avg_count, avg_target} <= '0;
        {current_level, current_mute_level} <= {16'h0011, 16'h0010};
        {voltage_level, voltage_mute_level} <= {16'h0011, 16'h0010};
    endtask

    // Levels toggle across the mute boundary itself
    task automatic drive_src(input int k, input logic on);
        @(posedge clk);
        case (k)
            0: range_search_active <= on;
            1: current_leads_voltage <= on;
            2: integ_time_up <= on;
            3: integ_running <= on;
            4: integ_paused <= on;
            5: acquisition_active <= on;
            6: trigger_wait <= on;
            7: avg_target <= {15'h0000, on};
            8: current_level <= on ? 16'h0010 : 16'h0011;
            default: voltage_level <= on ? 16'h0010 : 16'h0011;
        endcase
    endtask

    task automatic rand_in();
        @(posedge clk);
        {range_search_active, current_leads_voltage, integ_time_up} <= 3'($urandom);
        {integ_running, integ_paused, acquisition_active, trigger_wait} <= 4'($urandom);
        avg_count <= 16'($urandom_range(0, 2));
        avg_target <= 16'($urandom_range(0, 2));
        current_level <= 16'($urandom_range(8, 10));
        current_mute_level <= 16'h0009;
        voltage_mute_level <= 16'($urandom_range(8, 10));
        voltage_level <= 16'h0009;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        srst = 1'b1;
        void'($urandom(74));
        idle();
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        q(OSG_CMD_ENAB_Q, 16'h0000);
        q(OSG_CMD_NTR_Q, 16'h0000);
        q(OSG_CMD_PTR_Q, 16'h037f);
        q(OSG_CMD_EVENT_Q, 16'h0000);
        q(OSG_CMD_COND_Q, 16'h0000);
        $display("test reset_values done");
        for (int k = 0; k < 10; k++) begin
            drive_src(k, 1'b1);
            q(OSG_CMD_COND_Q, wt[k]);
            q(OSG_CMD_COND_Q, wt[k]);
            drive_src(k, 1'b0);
        end
        q(OSG_CMD_EVENT_Q, 16'h037f);
        q(OSG_CMD_EVENT_Q, 16'h0000);
        $display("test condition_bits done");
        send(OSG_CMD_ENAB_SET, 16'h0010);
        send(OSG_CMD_PTR_SET, 16'h0000);
        send(OSG_CMD_NTR_SET, 16'h0010);
        drive_src(5, 1'b1);
        repeat (3) @(posedge clk);
        q(OSG_CMD_EVENT_Q, 16'h0000);
        drive_src(5, 1'b0);
        repeat (3) @(posedge clk);
        chk(normal_activity_summary, 1'b1);
        q(OSG_CMD_EVENT_Q, 16'h0010);
        send(OSG_CMD_ENAB_SET, 16'h8000);
        q(OSG_CMD_ENAB_Q, 16'h0010);
        send(OSG_CMD_NTR_SET, 16'hffff);
        q(OSG_CMD_NTR_Q, 16'h0010);
        send(OSG_CMD_PTR_SET, 16'h7fff);
        q(OSG_CMD_PTR_Q, 16'h037f);
        send(OSG_CMD_ENAB_SET, 16'h7fff);
        q(OSG_CMD_ENAB_Q, 16'h037f);
        $display("test filters_and_refusal done");
        repeat (12) begin
            send(OSG_CMD_PTR_SET, 16'($urandom) & 16'h7fff);
            send(OSG_CMD_NTR_SET, 16'($urandom) & 16'h7fff);
            send(OSG_CMD_ENAB_SET, 16'($urandom) & 16'h7fff);
            repeat (20) rand_in();
            send(OSG_CMD_EVENT_Q, 16'h0000);
            send(OSG_CMD_COND_Q, 16'h0000);
        end
        $display("test random_traffic done");
        end_sim();
    end
endmodule
